// ### rtpb_pkg.sv
/*
  Constants, bus carriers and state layout for the reload timer with
  event counter, buzzer toggle and PWM output.
  Assumes an AXI4-Lite master with 32-bit data and a 12-bit byte address.
*/
// Functional notes
// [R01] outside PWM every overflow reloads the counter from the reload register automatically
// [R02] reload writes land in a holding buffer, moved to active at overflow
// [R03] software writes counter and reload equal before first enable
// [R04] software changes a running interval through reload, effective after overflow
// [R05] clock source select 1 counts falling edges of the event pin
// [R06] event counting overflows when the counter wraps from 0xFF to 0x00; the code loads the reload value after 0xFF instead
// [R07] event counting disables the event pin wake-up function
// [R08] event counting disables the pin interrupt and holds its flag at zero
// [R09] buzzer output inverts at each overflow, period two intervals
// [R10] buzzer and PWM overflows still set the flag and request interrupt
// [R11] toggle enable steers the shared pin to the buzzer, clear restores GPIO
// [R12] software keeps PWM enable 0 while using the buzzer
// [R13] enabled timer with PWM enable drives high phase then low phase
// [R14] in PWM the counter starts from zero at enable and after overflow
// [R15] in PWM the output goes low when counter equals the duty value
// [R16] in PWM an overflow ends the cycle and drives the output high
// [R17] a new duty takes effect at the next cycle via overflow transfer
// [R18] reload and toggle bits choose 256, 64, 32 or 16 PWM steps
// [R19] software keeps the duty inside the chosen resolution range
// [R20] PWM enable steers the pin to PWM, clear restores GPIO, timer runs
// [R21] PWM: prescaler sets cycle, resolution bits steps, reload the high width
// [R22] prescaler select 000..111 divides by 256 down to 2
// [R23] counter holds while the enable bit is 0, counts while 1
// [R24] each overflow sets the overflow flag until software clears it
// [R25] reload and toggle bits act as such only while PWM enable is 0
// [R26] the event pin is synchronised before falling edges are detected
// [R27] in PWM the active buffer updates at every overflow regardless of reload bit
package rtpb_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] RTPB_IDX_RELOAD = 8'hCD;
  localparam logic [7:0] RTPB_IDX_MODE = 8'hDA;
  localparam logic [7:0] RTPB_IDX_COUNT = 8'hDB;
  localparam logic [7:0] RTPB_IDX_FLAGS = 8'hCE;
  localparam logic [1:0] RTPB_ADDR_HI = 2'h0;

  // mode_control fields
  localparam int RTPB_MB_PWM = 0;
  localparam int RTPB_MB_TOG = 1;
  localparam int RTPB_MB_ALD = 2;
  localparam int RTPB_MB_CKS = 3;
  localparam int RTPB_MB_RATE = 4;
  localparam int RTPB_MB_ENB = 7;

  // flags register fields
  localparam int RTPB_FB_OVF = 0;
  localparam int RTPB_FB_IEN = 1;
  localparam int RTPB_FB_EVIRQ = 2;

  localparam logic [7:0] RTPB_RST_BYTE = 8'h00;
  localparam logic [7:0] RTPB_CNT_ONE = 8'h01;
  localparam logic [7:0] RTPB_MASK_256 = 8'hFF;
  localparam logic [7:0] RTPB_MASK_64 = 8'h3F;
  localparam logic [7:0] RTPB_MASK_32 = 8'h1F;
  localparam logic [7:0] RTPB_MASK_16 = 8'h0F;

  localparam logic [1:0] RTPB_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTPB_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } rtpb_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtpb_axi_rsp_s;

  typedef struct packed {
    rtpb_axi_rsp_s rsp;
    logic aw_ok;
    logic [11:0] aw_addr;
    logic w_ok;
    logic [7:0] w_data;
    logic w_lane;
    logic [7:0] mode;
    logic [7:0] cnt;
    logic [7:0] hold;
    logic [7:0] active;
    logic ovf;
    logic ien;
    logic evirq;
    logic [7:0] presc;
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic enb_d;
    logic pwm_lvl;
    logic buzz;
    logic pin_out;
    logic pin_oe;
    logic wake_en;
    logic pin_irq_en;
    logic irq;
  } rtpb_state_s;

endpackage : rtpb_pkg

// ### rtpb_timer.sv
/*
  Reload timer: 8-bit up counter with double-buffered reload, event
  counting on a pin, buzzer toggle and PWM on a shared output pin.
  Assumes an AXI4-Lite master on clk_sys, the GPIO block on the same
  clock, and an event pin that is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module rtpb_timer
  import rtpb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register bus
  input wire rtpb_axi_req_s s_axi_req,
  output rtpb_axi_rsp_s s_axi_rsp,
  // event pin and its GPIO side
  input wire logic event_input_pin,
  output logic event_wake_enable,
  output logic event_pin_irq_enable,
  output logic event_pin_irq_flag,
  // shared waveform pin and its GPIO setting
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic waveform_output_pin_out,
  output logic waveform_output_pin_oe,
  // overflow interrupt request
  output logic overflow_irq
);

  rtpb_state_s s;
  rtpb_state_s n;

  logic enb;
  logic pwm;
  logic cks;
  logic [7:0] pmask;
  logic [7:0] bmask;
  logic tick;
  logic ev_fall;
  logic at_top;
  logic ovf_ev;
  logic pwm_start;
  logic do_wr;
  logic wr_hit;
  logic wr_mode;
  logic wr_cnt;
  logic wr_rel;
  logic wr_flg;
  logic [7:0] cnt_inc;
  logic [7:0] duty;

  always_comb begin
    n = s;
    enb = s.mode[RTPB_MB_ENB];
    pwm = s.mode[RTPB_MB_PWM];
    cks = s.mode[RTPB_MB_CKS];
    cnt_inc = 8'(s.cnt + RTPB_CNT_ONE);

    // bus write channels, taken in either order
    if (s.rsp.bvalid && s_axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.rsp.awready && s_axi_req.awvalid) begin
      n.aw_ok = 1'b1;
      n.aw_addr = s_axi_req.awaddr;
    end
    if (s.rsp.wready && s_axi_req.wvalid) begin
      n.w_ok = 1'b1;
      n.w_data = s_axi_req.wdata[7:0];
      n.w_lane = s_axi_req.wstrb[0];
    end
    do_wr = s.aw_ok && s.w_ok && !s.rsp.bvalid;
    wr_hit = s.aw_addr[11:10] == RTPB_ADDR_HI;
    wr_mode = do_wr && wr_hit && s.w_lane && s.aw_addr[9:2] == RTPB_IDX_MODE;
    wr_cnt = do_wr && wr_hit && s.w_lane && s.aw_addr[9:2] == RTPB_IDX_COUNT;
    wr_rel = do_wr && wr_hit && s.w_lane && s.aw_addr[9:2] == RTPB_IDX_RELOAD;
    wr_flg = do_wr && wr_hit && s.w_lane && s.aw_addr[9:2] == RTPB_IDX_FLAGS;
    if (do_wr) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.rsp.bvalid = 1'b1;
      if (wr_hit && (s.aw_addr[9:2] == RTPB_IDX_MODE || s.aw_addr[9:2] == RTPB_IDX_COUNT ||
          s.aw_addr[9:2] == RTPB_IDX_RELOAD || s.aw_addr[9:2] == RTPB_IDX_FLAGS)) begin
        n.rsp.bresp = RTPB_RESP_OKAY;
      end else begin
        n.rsp.bresp = RTPB_RESP_SLVERR;
      end
    end
    n.rsp.awready = !n.aw_ok && !n.rsp.bvalid;
    n.rsp.wready = !n.w_ok && !n.rsp.bvalid;

    // bus read channel; the reload register is write-only and reads zero
    if (s.rsp.rvalid && s_axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (s.rsp.arready && s_axi_req.arvalid) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata = '0;
      n.rsp.rresp = RTPB_RESP_OKAY;
      if (s_axi_req.araddr[11:10] != RTPB_ADDR_HI) begin
        n.rsp.rresp = RTPB_RESP_SLVERR;
      end else if (s_axi_req.araddr[9:2] == RTPB_IDX_MODE) begin
        n.rsp.rdata[7:0] = s.mode;
      end else if (s_axi_req.araddr[9:2] == RTPB_IDX_COUNT) begin
        n.rsp.rdata[7:0] = s.cnt;
      end else if (s_axi_req.araddr[9:2] == RTPB_IDX_FLAGS) begin
        n.rsp.rdata[RTPB_FB_OVF] = s.ovf;
        n.rsp.rdata[RTPB_FB_IEN] = s.ien;
        n.rsp.rdata[RTPB_FB_EVIRQ] = s.evirq;
      end else if (s_axi_req.araddr[9:2] != RTPB_IDX_RELOAD) begin
        n.rsp.rresp = RTPB_RESP_SLVERR;
      end
    end
    n.rsp.arready = !n.rsp.rvalid;

    // event pin: two flops, then a third stage for the edge
    n.ev_s1 = event_input_pin; // see [R26]
    n.ev_s2 = s.ev_s1;
    n.ev_s3 = s.ev_s2;
    ev_fall = s.ev_s3 && !s.ev_s2; // see [R26]

    // free-running prescaler; select 000 divides by 256, 111 by 2
    // never cleared, so the first tick after enable may come up to one divisor early
    n.presc = 8'(s.presc + RTPB_CNT_ONE);
    pmask = RTPB_MASK_256 >> s.mode[RTPB_MB_RATE +: 3]; // see [R22]
    tick = enb && (cks ? ev_fall : (s.presc & pmask) == pmask); // see [R05] [R23]

    // overflow boundary follows the PWM resolution
    if (!pwm) begin
      bmask = RTPB_MASK_256; // see [R25] [R06]
    end else begin
      unique case ({s.mode[RTPB_MB_ALD], s.mode[RTPB_MB_TOG]}) // see [R18]
        2'b00: bmask = RTPB_MASK_256;
        2'b01: bmask = RTPB_MASK_64;
        2'b10: bmask = RTPB_MASK_32;
        2'b11: bmask = RTPB_MASK_16;
      endcase
    end
    at_top = (s.cnt & bmask) == bmask;
    // a stale count on the PWM start cycle is no overflow; the cycle restarts at zero
    pwm_start = pwm && enb && !s.enb_d;
    ovf_ev = tick && at_top && !pwm_start;
    duty = s.active & bmask; // see [R21]

    // counting and overflow
    n.enb_d = enb;
    if (pwm_start) begin
      n.cnt = RTPB_RST_BYTE; // see [R14]
      n.pwm_lvl = 1'b1; // see [R13]
    end else if (ovf_ev) begin
      n.active = s.hold; // see [R02] [R27] [R17]
      n.cnt = pwm ? RTPB_RST_BYTE : s.hold; // see [R01] [R14]
      n.buzz = !s.buzz; // see [R09]
      n.pwm_lvl = 1'b1; // see [R16]
    end else begin
      if (tick) begin
        n.cnt = cnt_inc;
      end
      if (pwm && enb && s.cnt == duty) begin
        n.pwm_lvl = 1'b0; // see [R15]
      end
    end

    // software writes win over the counter's own step
    if (wr_mode) begin
      n.mode = s.w_data;
    end
    if (wr_cnt) begin
      n.cnt = s.w_data;
    end
    if (wr_rel) begin
      n.hold = s.w_data; // see [R02]
      // a stopped timer has no cycle to protect, so the duty applies at once
      if (!enb) begin
        n.active = s.w_data;
      end
    end

    // flags: write 1 clears, a set in the same cycle wins
    if (wr_flg) begin
      n.ien = s.w_data[RTPB_FB_IEN];
      if (s.w_data[RTPB_FB_OVF]) begin
        n.ovf = 1'b0;
      end
      if (s.w_data[RTPB_FB_EVIRQ]) begin
        n.evirq = 1'b0;
      end
    end
    if (ovf_ev) begin
      n.ovf = 1'b1; // see [R24] [R10]
    end
    if (ev_fall) begin
      n.evirq = 1'b1;
    end
    if (n.mode[RTPB_MB_CKS]) begin
      n.evirq = 1'b0; // see [R08]
    end
    n.wake_en = !n.mode[RTPB_MB_CKS]; // see [R07]
    n.pin_irq_en = !n.mode[RTPB_MB_CKS]; // see [R08]
    n.irq = n.ovf && n.ien; // see [R10]

    // shared pin: PWM first, then buzzer, else the GPIO setting
    if (n.mode[RTPB_MB_PWM]) begin
      n.pin_oe = 1'b1; // see [R20]
      n.pin_out = n.mode[RTPB_MB_ENB] && n.pwm_lvl; // see [R13]
    end else if (n.mode[RTPB_MB_TOG]) begin
      n.pin_oe = 1'b1; // see [R11]
      n.pin_out = n.buzz;
    end else begin
      n.pin_oe = gpio_oe; // see [R11] [R20]
      n.pin_out = gpio_out;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign s_axi_rsp = s.rsp;
  assign event_wake_enable = s.wake_en;
  assign event_pin_irq_enable = s.pin_irq_en;
  assign event_pin_irq_flag = s.evirq;
  assign waveform_output_pin_out = s.pin_out;
  assign waveform_output_pin_oe = s.pin_oe;
  assign overflow_irq = s.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  ovf_flag_set_a: assert property (ovf_ev |=> s.ovf) // see [R24]
    else $error("overflow did not set the flag");

  reload_load_a: assert property ( // see [R01]
    ovf_ev && !pwm && !wr_cnt && !(enb && !s.enb_d) |=> s.cnt == $past(s.hold))
    else $error("counter not reloaded at overflow");

  active_xfer_a: assert property (ovf_ev && !wr_rel |=> s.active == $past(s.hold)) // see [R02]
    else $error("active buffer not moved at overflow");

  hold_when_off_a: assert property (!enb && !wr_cnt |=> $stable(s.cnt)) // see [R23]
    else $error("counter moved while disabled");

  event_step_a: assert property ( // see [R05]
    enb && cks && ev_fall && !at_top && !wr_cnt && !wr_mode |=> s.cnt == $past(cnt_inc))
    else $error("event edge not counted");

  event_irq_zero_a: assert property (cks && !wr_mode |=> !s.evirq && !s.wake_en) // see [R08]
    else $error("event pin flag or wake-up active while counting");

  buzz_toggle_a: assert property (ovf_ev && !pwm |=> s.buzz != $past(s.buzz)) // see [R09]
    else $error("buzzer did not toggle");

  pwm_high_a: assert property (ovf_ev && pwm && !wr_mode |=> s.pin_out && s.pin_oe) // see [R16]
    else $error("PWM not high after overflow");

  pwm_low_a: assert property ( // see [R15]
    pwm && enb && s.enb_d && s.cnt == duty && !ovf_ev && !wr_mode |=> !s.pin_out)
    else $error("PWM not low at duty match");

  irq_req_a: assert property (ovf_ev && s.ien && !wr_flg |=> overflow_irq) // see [R10]
    else $error("no interrupt request on overflow");

  buzz_pin_a: assert property ( // see [R11]
    !pwm && s.mode[RTPB_MB_TOG] && !wr_mode |=> s.pin_oe && s.pin_out == s.buzz)
    else $error("buzzer not on the pin");

  pwm_start_a: assert property ( // see [R14]
    pwm_start && !wr_cnt |=> s.cnt == RTPB_RST_BYTE && s.pwm_lvl)
    else $error("PWM cycle did not start from zero");

  pin_gpio_a: assert property ( // see [R20]
    !pwm && !s.mode[RTPB_MB_TOG] && !wr_mode |=>
    s.pin_oe == $past(gpio_oe) && s.pin_out == $past(gpio_out))
    else $error("pin not returned to GPIO setting");

  pin_irq_off_a: assert property ( // see [R08]
    cks && !wr_mode |=> !event_pin_irq_enable)
    else $error("event pin interrupt enabled while counting");

  irq_masked_a: assert property ( // see [R10]
    !s.ien && !wr_flg |=> !overflow_irq)
    else $error("interrupt request while not enabled");

  pwm_ovf_c: cover property (ovf_ev && pwm);
  pwm_start_c: cover property (pwm_start);
  event_ovf_c: cover property (ovf_ev && cks);
  buzz_ovf_c: cover property (ovf_ev && s.mode[RTPB_MB_TOG] && !pwm);
  flag_race_c: cover property (ovf_ev && wr_flg && s.w_data[RTPB_FB_OVF]);

endmodule : rtpb_timer
`default_nettype wire

// ### rtpb_timer_test.sv
/*
  Self-checking bench for rtpb_timer: register access over AXI4-Lite, timer
  reload, prescaler, event counting, buzzer and PWM on the shared pin.
  Assumes the timer alone, clocked at 25 MHz, with the bench as bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module rtpb_timer_test;
  import rtpb_pkg::*;
  localparam logic [11:0] A_MODE = {RTPB_ADDR_HI, RTPB_IDX_MODE, 2'h0};
  localparam logic [11:0] A_CNT = {RTPB_ADDR_HI, RTPB_IDX_COUNT, 2'h0};
  localparam logic [11:0] A_REL = {RTPB_ADDR_HI, RTPB_IDX_RELOAD, 2'h0};
  localparam logic [11:0] A_FLG = {RTPB_ADDR_HI, RTPB_IDX_FLAGS, 2'h0};
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  rtpb_axi_req_s rq = '0;
  rtpb_axi_rsp_s rs;
  logic ev = 1'b1;
  logic go = 1'b0;
  logic ge = 1'b0;
  logic wk, pie, pif, po, poe, irq;
  int n_errors = 0;
  int checks = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [31:0] v;
  logic [11:0] regs [4] = '{A_MODE, A_CNT, A_REL, A_FLG};
  int st [4] = '{256, 64, 32, 16};
  int c, h;

  always #20 clk_sys = ~clk_sys;

  rtpb_timer dut (
    .clk_sys(clk_sys), .resetn(resetn), .s_axi_req(rq), .s_axi_rsp(rs),
    .event_input_pin(ev), .event_wake_enable(wk), .event_pin_irq_enable(pie),
    .event_pin_irq_flag(pif), .gpio_out(go), .gpio_oe(ge),
    .waveform_output_pin_out(po), .waveform_output_pin_oe(poe), .overflow_irq(irq));

  task tally_and_finish;
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // the first edge keeps a release from the previous call apart from the new raise
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    rq.awaddr <= a;
    rq.awvalid <= 1'b1;
    rq.wdata <= {24'h0, d};
    rq.wvalid <= 1'b1;
    rq.wstrb <= 4'hF;
    rq.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rs.awready === 1'b1) rq.awvalid <= 1'b0;
      if (rs.wready === 1'b1) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1);
    resp = rs.bresp;
    rq.bready <= 1'b0;
  endtask : wr

  task rdr(input logic [11:0] a);
    @(posedge clk_sys);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (rs.arready === 1'b1) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1);
    rd = rs.rdata;
    resp = rs.rresp;
    rq.rready <= 1'b0;
  endtask : rdr

  task clks(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : clks

  task gap;
    logic p;
    p = po;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (po === p && c < 9000);
  endtask : gap

  initial begin
    clks(8);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdr(regs[i]);
      chk("reset value", 32'h0, rd);
      chk("read resp", {30'h0, RTPB_RESP_OKAY}, {30'h0, resp});
    end
    rdr(12'h000);
    chk("unmapped read resp", {30'h0, RTPB_RESP_SLVERR}, {30'h0, resp});
    wr(12'h000, 8'h5A);
    chk("unmapped write resp", {30'h0, RTPB_RESP_SLVERR}, {30'h0, resp});
    wr(A_REL, 8'hA5);
    rdr(A_REL);
    chk("reload write only", 32'h0, rd);
    wr(A_MODE, 8'h7E);
    rdr(A_MODE);
    chk("mode rw", 32'h7E, rd);
    wr(A_FLG, 8'h02);
    // buzzer half period is 16 reload steps times the prescale divisor
    for (int s = 0; s < 8; s++) begin
      wr(A_MODE, 8'h00);
      wr(A_CNT, 8'hF0);
      wr(A_REL, 8'hF0);
      wr(A_MODE, 8'h82 | 8'(s << 4));
      gap();
      gap();
      chk("buzzer half period", 32'(16 * (256 >> s)), c);
      chk("buzzer oe", 32'h1, {31'h0, poe});
    end
    // a new interval written while running applies from the next overflow on
    wr(A_REL, 8'hF8);
    gap();
    gap();
    chk("new interval", 32'd16, c);
    chk("overflow irq", 32'h1, {31'h0, irq});
    rdr(A_FLG);
    chk("flags after overflow", 32'h03, rd);
    wr(A_MODE, 8'h00);
    rdr(A_CNT);
    v = rd;
    clks(40);
    rdr(A_CNT);
    chk("counter holds", v, rd);
    wr(A_FLG, 8'h03);
    rdr(A_FLG);
    chk("flag cleared", 32'h02, rd);
    go <= 1'b1;
    ge <= 1'b0;
    clks(3);
    chk("gpio oe back", 32'h0, {31'h0, poe});
    // a pin edge outside event counting raises the pin flag
    ev <= 1'b0;
    clks(5);
    ev <= 1'b1;
    clks(5);
    chk("pin flag", 32'h1, {31'h0, pif});
    wr(A_CNT, 8'hFE);
    wr(A_REL, 8'h10);
    wr(A_MODE, 8'h88);
    clks(3);
    chk("wake off", 32'h0, {31'h0, wk});
    chk("pin irq off", 32'h0, {31'h0, pie});
    chk("pin flag held", 32'h0, {31'h0, pif});
    for (int i = 0; i < 3; i++) begin
      ev <= 1'b0;
      clks(4);
      ev <= 1'b1;
      clks(4);
    end
    clks(4);
    rdr(A_CNT);
    chk("event count", 32'h11, rd);
    rdr(A_FLG);
    chk("event overflow", 32'h03, rd);
    go <= 1'b0;
    ge <= 1'b1;
    // high phase: duty steps of two clocks, plus the clock that registers the fall
    for (int m = 0; m < 4; m++) begin
      wr(A_MODE, 8'h00);
      wr(A_REL, 8'h03);
      wr(A_MODE, 8'hF1 | 8'(m << 1));
      clks(2 * st[m]);
      h = 0;
      repeat (4 * st[m]) begin
        @(posedge clk_sys);
        if (po === 1'b1) h++;
      end
      chk("pwm high time", 32'd14, h);
      chk("pwm oe", 32'h1, {31'h0, poe});
    end
    // a duty written mid-cycle waits for the next overflow
    wr(A_REL, 8'h05);
    clks(64);
    h = 0;
    repeat (64) begin
      @(posedge clk_sys);
      if (po === 1'b1) h++;
    end
    chk("pwm new duty", 32'd22, h);
    wr(A_MODE, 8'hF0);
    clks(3);
    chk("gpio out back", {31'h0, go}, {31'h0, po});
    chk("gpio oe kept", {31'h0, ge}, {31'h0, poe});
    rdr(A_CNT);
    v = rd;
    rdr(A_CNT);
    chk("timer runs", 32'h1, {31'h0, rd != v});
    tally_and_finish();
  end

  initial begin
    clks(80000);
    n_errors++;
    tally_and_finish();
  end
endmodule : rtpb_timer_test
`default_nettype wire
